//--- bcm_cfg.svh
// Purpose : constants for the breaker condition and state monitor
// Assumes : 100 MHz system clock
// Notes   : times are kept in their own unit; cycle counts derive from them
`ifndef BCM_CFG_SVH
`define BCM_CFG_SVH

// ****************************************************************
// timing
// ****************************************************************
`define BCM_CLK_PERIOD_NS   10
`define BCM_MS_NS           1000000
`define BCM_TICK_CYCLES     (`BCM_MS_NS / `BCM_CLK_PERIOD_NS)
`define BCM_MS_PER_S        1000
`define BCM_DISC_DELAY_MS   5000

// ****************************************************************
// setting limits and reset values
// ****************************************************************
`define BCM_EXP_MIN         5'h0a
`define BCM_EXP_MAX         5'h14
`define BCM_EXP_RESET       5'h14
`define BCM_EXP_DIVISOR     10
`define BCM_OPTIME_MIN_MS   10'h005
`define BCM_OPTIME_MAX_MS   10'h1f4

`endif

//--- bcm_pkg.sv
// Purpose : types shared by the breaker condition and state monitor
// Assumes : nothing
// Notes   : enumerations only; numbers live in bcm_cfg.svh
`default_nettype none

package bcm_pkg;

    // ****************************************************************
    // status source selection and decoded breaker state
    // ****************************************************************
    typedef enum logic [1:0] {
        BCM_SRC_NONE,
        BCM_SRC_NO_ONLY,
        BCM_SRC_NC_ONLY,
        BCM_SRC_BOTH
    } bcm_src_t;

    typedef enum logic [2:0] {
        BCM_ST_NONE,
        BCM_ST_OPEN,
        BCM_ST_CLOSED,
        BCM_ST_UNKNOWN,
        BCM_ST_FAILURE
    } bcm_state_t;

endpackage

`default_nettype wire

//--- bcm_monitor.sv
// Purpose : breaker condition statistics and auxiliary contact state monitor
// Assumes : trip, current and timing inputs come from logic on i_clk_sys;
//           auxiliary contact inputs come from pins; contact closed reads 1
// Notes   : broken-current power uses a log/antilog approximation
//
// Summary of operation
// - statistics advance only on issued trip
// - statistics read only, cleared by clear control
// - test mode freezes every statistics counter and the accumulator
// - add current raised to exponent per trip
// - exponent 1.0 to 2.0 step 0.1
// - maintenance alarm at operations maintenance threshold
// - reclose lockout at operations lockout threshold
// - interrupting time checked against alarm, lockout
// - windowed operation count alarm and lockout
// - open contact follows breaker, closed opposes
// - source is none, open, closed, both
// - source none reports no breaker status
// - open-only derives complement, no discrepancy alarm
// - closed-only derives complement, no discrepancy alarm
// - both: opposite contacts decode open or closed
// - both open reads as unknown state
// - both closed reads as breaker failure
// - discrepancy alarm after more than 5 s
`include "bcm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bcm_monitor #(
    parameter int TICK_CYCLES = `BCM_TICK_CYCLES,
    parameter int CUR_W       = 16,
    parameter int ACC_W       = 48,
    parameter int OPS_W       = 16
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_trip,
    input  wire logic                  i_test_mode,
    input  wire logic                  i_breaker_stats_clear,
    input  wire logic [CUR_W-1:0]      i_fault_current,
    input  wire logic [4:0]            i_exponent_tenths,
    input  wire logic [9:0]            i_op_time_ms,
    input  wire logic [OPS_W-1:0]      i_ops_maint_threshold,
    input  wire logic [OPS_W-1:0]      i_ops_lockout_threshold,
    input  wire logic [9:0]            i_op_time_alarm_threshold,
    input  wire logic [9:0]            i_op_time_lockout_threshold,
    input  wire logic [13:0]           i_freq_window_s,
    input  wire logic [OPS_W-1:0]      i_freq_alarm_threshold,
    input  wire logic [OPS_W-1:0]      i_freq_lockout_threshold,
    input  wire bcm_pkg::bcm_src_t     i_breaker_status_source,
    input  wire logic                  i_aux_no,
    input  wire logic                  i_aux_nc,
    output logic [OPS_W-1:0]           o_ops_count,
    output logic [ACC_W-1:0]           o_broken_current_acc,
    output logic [OPS_W-1:0]           o_freq_count,
    output logic [4:0]                 o_exponent_active,
    output logic                       o_exponent_rejected,
    output logic                       o_ops_maint_alarm,
    output logic                       o_ops_lockout,
    output logic                       o_op_time_alarm,
    output logic                       o_op_time_lockout,
    output logic                       o_freq_alarm,
    output logic                       o_freq_lockout,
    output bcm_pkg::bcm_state_t        o_breaker_state,
    output logic                       o_breaker_open,
    output logic                       o_breaker_closed,
    output logic                       o_discrepancy_alarm
);
    import bcm_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    generate
        if (TICK_CYCLES < 1 || CUR_W != 16 || ACC_W < 41 || OPS_W < 2)
        begin : g_bad_param
            $error("bcm_monitor: unsupported parameter values");
        end
    endgenerate

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
    localparam int          DISC_MS   = `BCM_DISC_DELAY_MS;

    // ****************************************************************
    // broken-current power: 2^(e/10 * log2(i)), piecewise linear
    // ****************************************************************
    function automatic logic [39:0] bcm_power(input logic [15:0] cur,
                                              input logic [4:0]  e);
        logic [3:0]  msb;
        logic [15:0] norm;
        logic [11:0] lg;
        logic [16:0] prod;
        logic [12:0] y;
        logic [39:0] man;
        msb  = 4'h0;
        for (int k = 0; k < 16; k++)
            if (cur[k])
                msb = 4'(k);
        norm = cur << (4'hf - msb);
        lg   = {msb, norm[14:7]};
        prod = 17'(lg * e);
        y    = 13'(prod / `BCM_EXP_DIVISOR);
        man  = {31'h0, 1'b1, y[7:0]};
        man  = man << y[12:8];
        if (cur == 16'h0000)
            bcm_power = 40'h0;
        else
            bcm_power = {8'h00, man[39:8]};
    endfunction

    // ****************************************************************
    // common qualifiers
    // ****************************************************************
    logic        count_en;
    logic        exp_ok;
    logic [39:0] pow_w;

    assign count_en = i_trip && !i_test_mode && !i_breaker_stats_clear;
    assign exp_ok   = (i_exponent_tenths >= `BCM_EXP_MIN)
                   && (i_exponent_tenths <= `BCM_EXP_MAX);
    assign pow_w    = bcm_power(i_fault_current, o_exponent_active);

    // ****************************************************************
    // millisecond tick divider
    // ****************************************************************
    logic [31:0] tick_cnt_q;
    logic        ms_tick_q;

    // one-cycle pulse every millisecond
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tick_cnt_q <= 32'h0;
            ms_tick_q  <= 1'b0;
        end
        else
        begin
            ms_tick_q  <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // ****************************************************************
    // exponent setting
    // ****************************************************************
    // accept only in-range settings, otherwise keep the last good one
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_exponent_active   <= `BCM_EXP_RESET;
            o_exponent_rejected <= 1'b0;
        end
        else
        begin
            o_exponent_rejected <= !exp_ok;
            if (exp_ok)
                o_exponent_active <= i_exponent_tenths;
        end
    end

    // ****************************************************************
    // operations count and broken-current accumulator
    // ****************************************************************
    // saturating count; clear has priority over a trip in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ops_count          <= '0;
            o_broken_current_acc <= '0;
        end
        else if (i_breaker_stats_clear)
        begin
            o_ops_count          <= '0;
            o_broken_current_acc <= '0;
        end
        else if (count_en)
        begin
            if (o_ops_count != '1)
                o_ops_count <= o_ops_count + 1'b1;
            o_broken_current_acc <= o_broken_current_acc + ACC_W'(pow_w);
        end
    end

    // level alarms follow the count against the thresholds
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ops_maint_alarm <= 1'b0;
            o_ops_lockout     <= 1'b0;
        end
        else
        begin
            o_ops_maint_alarm <= (o_ops_count >= i_ops_maint_threshold);
            o_ops_lockout     <= (o_ops_count >= i_ops_lockout_threshold);
        end
    end

    // ****************************************************************
    // interrupting time check
    // ****************************************************************
    logic alarm_thr_ok;
    logic lock_thr_ok;

    assign alarm_thr_ok = (i_op_time_alarm_threshold >= `BCM_OPTIME_MIN_MS)
                       && (i_op_time_alarm_threshold <= `BCM_OPTIME_MAX_MS);
    assign lock_thr_ok  = (i_op_time_lockout_threshold >= `BCM_OPTIME_MIN_MS)
                       && (i_op_time_lockout_threshold <= `BCM_OPTIME_MAX_MS);

    // latched on a slow trip until statistics are cleared
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_op_time_alarm   <= 1'b0;
            o_op_time_lockout <= 1'b0;
        end
        else if (i_breaker_stats_clear)
        begin
            o_op_time_alarm   <= 1'b0;
            o_op_time_lockout <= 1'b0;
        end
        else if (count_en)
        begin
            if (alarm_thr_ok && i_op_time_ms > i_op_time_alarm_threshold)
                o_op_time_alarm <= 1'b1;
            if (lock_thr_ok && i_op_time_ms > i_op_time_lockout_threshold)
                o_op_time_lockout <= 1'b1;
        end
    end

    // ****************************************************************
    // excessive fault frequency
    // ****************************************************************
    logic        win_active_q;
    logic [23:0] win_ms_q;
    logic [23:0] win_limit;

    assign win_limit = 24'(i_freq_window_s * `BCM_MS_PER_S);

    // window opens on the first trip and closes after the set time
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            win_active_q <= 1'b0;
            win_ms_q     <= 24'h0;
            o_freq_count <= '0;
        end
        else if (i_breaker_stats_clear)
        begin
            win_active_q <= 1'b0;
            win_ms_q     <= 24'h0;
            o_freq_count <= '0;
        end
        else if (!i_test_mode)
        begin
            if (count_en && !win_active_q)
            begin
                win_active_q <= 1'b1;
                win_ms_q     <= 24'h0;
                o_freq_count <= {{(OPS_W-1){1'b0}}, 1'b1};
            end
            else if (win_active_q && win_ms_q >= win_limit)
            begin
                win_active_q <= 1'b0;
                o_freq_count <= '0;
            end
            else
            begin
                if (count_en && o_freq_count != '1)
                    o_freq_count <= o_freq_count + 1'b1;
                if (win_active_q && ms_tick_q)
                    win_ms_q <= win_ms_q + 24'h1;
            end
        end
    end

    // windowed count against its own thresholds
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_freq_alarm   <= 1'b0;
            o_freq_lockout <= 1'b0;
        end
        else
        begin
            o_freq_alarm   <= (o_freq_count >= i_freq_alarm_threshold);
            o_freq_lockout <= (o_freq_count >= i_freq_lockout_threshold);
        end
    end

    // ****************************************************************
    // auxiliary contact synchronisers
    // ****************************************************************
    logic [1:0] no_sync_q;
    logic [1:0] nc_sync_q;

    // two flops per pin; only the second flop (bit 1) is read by the decoder
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            no_sync_q <= 2'b00;
            nc_sync_q <= 2'b00;
        end
        else
        begin
            no_sync_q <= {no_sync_q[0], i_aux_no};
            nc_sync_q <= {nc_sync_q[0], i_aux_nc};
        end
    end

    // ****************************************************************
    // state decode
    // ****************************************************************
    logic       no_w;
    logic       nc_w;
    bcm_state_t state_d;

    assign no_w = no_sync_q[1];
    assign nc_w = nc_sync_q[1];

    // open contact follows the breaker, closed contact opposes it
    always_comb
    begin
        state_d = BCM_ST_NONE;
        unique case (i_breaker_status_source)
            BCM_SRC_NONE:    state_d = BCM_ST_NONE;
            BCM_SRC_NO_ONLY: state_d = no_w ? BCM_ST_CLOSED : BCM_ST_OPEN;
            BCM_SRC_NC_ONLY: state_d = nc_w ? BCM_ST_OPEN : BCM_ST_CLOSED;
            BCM_SRC_BOTH:
            begin
                unique case ({no_w, nc_w})
                    2'b01: state_d = BCM_ST_OPEN;
                    2'b10: state_d = BCM_ST_CLOSED;
                    2'b00: state_d = BCM_ST_UNKNOWN;
                    2'b11: state_d = BCM_ST_FAILURE;
                endcase
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_breaker_state  <= BCM_ST_NONE;
            o_breaker_open   <= 1'b0;
            o_breaker_closed <= 1'b0;
        end
        else
        begin
            o_breaker_state  <= state_d;
            o_breaker_open   <= (state_d == BCM_ST_OPEN);
            o_breaker_closed <= (state_d == BCM_ST_CLOSED);
        end
    end

    // ****************************************************************
    // discrepancy persistence timer
    // ****************************************************************
    logic        bad_w;
    logic [12:0] disc_ms_q;

    assign bad_w = (state_d == BCM_ST_UNKNOWN) || (state_d == BCM_ST_FAILURE);

    // counts whole ms of continuous disagreement; healthy restarts it
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            disc_ms_q           <= 13'h0;
            o_discrepancy_alarm <= 1'b0;
        end
        else if (!bad_w)
        begin
            disc_ms_q           <= 13'h0;
            o_discrepancy_alarm <= 1'b0;
        end
        else
        begin
            if (ms_tick_q && disc_ms_q <= 13'(DISC_MS))
                disc_ms_q <= disc_ms_q + 13'h1;
            if (disc_ms_q > 13'(DISC_MS))
                o_discrepancy_alarm <= 1'b1;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    a_trip_counts_ops: assert property (
        count_en && o_ops_count != '1 |=> o_ops_count == $past(o_ops_count) + 1'b1)
        else $error("operations count did not advance on trip");

    a_idle_keeps_stats: assert property (
        !i_trip && !i_breaker_stats_clear
        |=> $stable(o_ops_count) && $stable(o_broken_current_acc))
        else $error("statistics changed without a trip");

    a_clear_zeroes_all: assert property (
        i_breaker_stats_clear
        |=> o_ops_count == '0 && o_broken_current_acc == '0 && o_freq_count == '0)
        else $error("clear did not zero all statistics");

    a_test_freezes_stats: assert property (
        i_test_mode && !i_breaker_stats_clear
        |=> $stable(o_ops_count) && $stable(o_broken_current_acc) && $stable(o_freq_count))
        else $error("statistics changed in test mode");

    a_acc_adds_power: assert property (
        count_en |=> o_broken_current_acc == $past(o_broken_current_acc) + ACC_W'($past(pow_w)))
        else $error("accumulator did not add the trip power");

    a_bad_exp_kept: assert property (
        !exp_ok |=> $stable(o_exponent_active) && o_exponent_rejected)
        else $error("rejected exponent was taken");

    a_maint_alarm_level: assert property (
        ##1 o_ops_maint_alarm == ($past(o_ops_count) >= $past(i_ops_maint_threshold)))
        else $error("maintenance alarm wrong for count");

    a_ops_lock_level: assert property (
        ##1 o_ops_lockout == ($past(o_ops_count) >= $past(i_ops_lockout_threshold)))
        else $error("operations lockout wrong for count");

    a_slow_trip_alarm: assert property (
        count_en && alarm_thr_ok && i_op_time_ms > i_op_time_alarm_threshold
        |=> o_op_time_alarm)
        else $error("slow interrupting time not alarmed");

    a_none_no_status: assert property (
        i_breaker_status_source == BCM_SRC_NONE |=> !o_breaker_open && !o_breaker_closed)
        else $error("status reported with source none");

    a_single_no_disc: assert property (
        i_breaker_status_source != BCM_SRC_BOTH |=> !o_discrepancy_alarm)
        else $error("discrepancy alarm with a single contact");

    a_disc_delay_held: assert property (
        $rose(o_discrepancy_alarm) |-> $past(disc_ms_q) > 13'(DISC_MS) && $past(bad_w))
        else $error("discrepancy alarm before the delay");

    a_healthy_drops_alarm: assert property (
        !bad_w |=> !o_discrepancy_alarm && disc_ms_q == 13'h0)
        else $error("healthy contacts kept the alarm or timer");

endmodule

`default_nettype wire

//--- bcm_aux_model.sv
// Purpose : auxiliary contact pair of the breaker, seen from the monitor
// Assumes : a closed contact reads 1
// Notes   : fault 1 opens both contacts, fault 2 or 3 closes both
`timescale 1ns/1ps
`default_nettype none

module bcm_aux_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_closed,
    input  wire logic [1:0] i_fault,
    output logic            o_aux_no,
    output logic            o_aux_nc
);
    // ****************************************************************
    // contact drive
    // ****************************************************************
    // open-type contact follows the breaker, closed-type opposes it
    always_ff @(posedge i_clk_sys)
    begin
        o_aux_no <= (i_fault == 2'h0) ? i_closed : i_fault[1];
        o_aux_nc <= (i_fault == 2'h0) ? !i_closed : i_fault[1];
    end
endmodule

`default_nettype wire

//--- bcm_monitor_tb_top.sv
// Purpose : self-checking bench for the breaker condition and state monitor
// Assumes : TICK_CYCLES of 4, so one millisecond is four clocks
// Notes   : contact decode runs from a table; statistics and delays by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module bcm_monitor_tb_top;
    import bcm_pkg::*;
    typedef struct packed {bcm_src_t src; logic cl; logic [1:0] flt;
        bcm_state_t st; logic op; logic cls;} bcm_row_t;
    // ****************************************************************
    // stimulus, table and checks
    // ****************************************************************
    localparam bcm_row_t ROWS [9] = '{
        '{BCM_SRC_NONE, 1'h1, 2'h0, BCM_ST_NONE, 1'h0, 1'h0},
        '{BCM_SRC_NO_ONLY, 1'h1, 2'h2, BCM_ST_CLOSED, 1'h0, 1'h1},
        '{BCM_SRC_NO_ONLY, 1'h0, 2'h1, BCM_ST_OPEN, 1'h1, 1'h0},
        '{BCM_SRC_NC_ONLY, 1'h1, 2'h1, BCM_ST_CLOSED, 1'h0, 1'h1},
        '{BCM_SRC_NC_ONLY, 1'h0, 2'h2, BCM_ST_OPEN, 1'h1, 1'h0},
        '{BCM_SRC_BOTH, 1'h1, 2'h0, BCM_ST_CLOSED, 1'h0, 1'h1},
        '{BCM_SRC_BOTH, 1'h0, 2'h0, BCM_ST_OPEN, 1'h1, 1'h0},
        '{BCM_SRC_BOTH, 1'h0, 2'h1, BCM_ST_UNKNOWN, 1'h0, 1'h0},
        '{BCM_SRC_BOTH, 1'h0, 2'h2, BCM_ST_FAILURE, 1'h0, 1'h0}};
    logic clk = 1'h0, rst_n = 1'h0, trip = 1'h0, test = 1'h0, clr = 1'h0;
    logic closed = 1'h0, aux_no, aux_nc, rej, mal, mlk, tal, tlk, fal, flk;
    logic bop, bcl, disc;
    logic [1:0] fault = 2'h0;
    logic [4:0] expo = 5'h14, exa;
    logic [9:0] opt = 10'h000, tath = 10'h064, tlth = 10'h0c8;
    logic [15:0] cur = 16'h0000, ops, fcnt, omth = 16'h0002, olth = 16'h0003;
    logic [47:0] acc;
    bcm_src_t src = BCM_SRC_NONE;
    bcm_state_t st;
    int mismatches = 0, n_compared = 0, w;

    always #5 clk = !clk;

    bcm_aux_model bcm_aux_model_i (.i_clk_sys(clk), .i_closed(closed), .i_fault(fault),
        .o_aux_no(aux_no), .o_aux_nc(aux_nc));

    bcm_monitor #(.TICK_CYCLES(4)) bcm_monitor_i (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_trip(trip), .i_test_mode(test), .i_breaker_stats_clear(clr),
        .i_fault_current(cur), .i_exponent_tenths(expo), .i_op_time_ms(opt),
        .i_ops_maint_threshold(omth), .i_ops_lockout_threshold(olth),
        .i_op_time_alarm_threshold(tath), .i_op_time_lockout_threshold(tlth),
        .i_freq_window_s(14'h0001), .i_freq_alarm_threshold(16'h0002),
        .i_freq_lockout_threshold(16'h0003), .i_breaker_status_source(src),
        .i_aux_no(aux_no), .i_aux_nc(aux_nc), .o_ops_count(ops),
        .o_broken_current_acc(acc), .o_freq_count(fcnt), .o_exponent_active(exa),
        .o_exponent_rejected(rej), .o_ops_maint_alarm(mal), .o_ops_lockout(mlk),
        .o_op_time_alarm(tal), .o_op_time_lockout(tlk), .o_freq_alarm(fal),
        .o_freq_lockout(flk), .o_breaker_state(st), .o_breaker_open(bop),
        .o_breaker_closed(bcl), .o_discrepancy_alarm(disc));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_trip(input logic [15:0] c, input logic [9:0] t);
        @(posedge clk);
        trip <= 1'h1;
        cur <= c;
        opt <= t;
        @(posedge clk);
        trip <= 1'h0;
        tick(2);
    endtask

    task automatic set_pins(input bcm_src_t s, input logic [1:0] f, input int n);
        @(posedge clk);
        src <= s;
        fault <= f;
        tick(n);
    endtask

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        tick(5);
        `CHK(exa, 5'h14)
        `CHK(ops, 16'h0000)
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        foreach (ROWS[k])
        begin
            @(posedge clk);
            closed <= ROWS[k].cl;
            set_pins(ROWS[k].src, ROWS[k].flt, 6);
            `CHK(st, ROWS[k].st)
            `CHK({bop, bcl}, {ROWS[k].op, ROWS[k].cls})
            `CHK(disc, 1'h0)
        end
        do_trip(16'h0010, 10'h032);
        `CHK({ops, fcnt, acc}, {16'h0001, 16'h0001, 48'h100})
        `CHK({mal, tal, fal}, 3'h0)
        @(posedge clk);
        expo <= 5'h0a;
        do_trip(16'h0010, 10'h065);
        `CHK({ops, fcnt, acc}, {16'h0002, 16'h0002, 48'h110})
        `CHK({mal, mlk, tal, tlk, fal, flk}, 6'h2a)
        @(posedge clk);
        expo <= 5'h19;
        test <= 1'h1;
        do_trip(16'h0010, 10'h12c);
        `CHK({rej, exa}, {1'h1, 5'h0a})
        `CHK({ops, fcnt, acc, tlk}, {16'h0002, 16'h0002, 48'h110, 1'h0})
        @(posedge clk);
        test <= 1'h0;
        do_trip(16'h0004, 10'h12c);
        `CHK({ops, fcnt, acc}, {16'h0003, 16'h0003, 48'h114})
        `CHK({mal, mlk, tal, tlk, fal, flk}, 6'h3f)
        @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        tick(3);
        `CHK({ops, fcnt, acc}, 80'h0)
        `CHK({mal, tal, tlk, fal}, 4'h0)
        // alarm time threshold below range disables that check only
        @(posedge clk);
        tath <= 10'h004;
        omth <= 16'h0001;
        do_trip(16'h0010, 10'h12c);
        `CHK({ops, fcnt, mal, mlk, tal, tlk}, {16'h0001, 16'h0001, 4'h9})
        // fault-frequency window of one second closes and drops the count
        tick(4100);
        `CHK({ops, fcnt, fal}, {16'h0001, 16'h0000, 1'h0})
        // healthy contacts first, so the persistence timer starts from zero
        set_pins(BCM_SRC_BOTH, 2'h0, 5);
        `CHK(disc, 1'h0)
        set_pins(BCM_SRC_BOTH, 2'h1, 19990);
        `CHK(disc, 1'h0)
        for (w = 0; w < 40 && disc !== 1'h1; w++)
            tick(1);
        `CHK(disc, 1'h1)
        set_pins(BCM_SRC_BOTH, 2'h0, 5);
        `CHK(disc, 1'h0)
        set_pins(BCM_SRC_BOTH, 2'h2, 12000);
        set_pins(BCM_SRC_BOTH, 2'h0, 8);
        set_pins(BCM_SRC_BOTH, 2'h2, 12000);
        `CHK(disc, 1'h0)
        set_pins(BCM_SRC_NO_ONLY, 2'h1, 20100);
        `CHK(disc, 1'h0)
        print_verdict();
    end
endmodule

`default_nettype wire
